// ---- design/lbc_top.sv ----
// Lighting driver configuration register bank behind the serial slave
`timescale 1ns/1ns
//
// Contract
// - Dither per bank a/b unless disabled
// - Mapping bits: 0 exponential, 1 linear
// - Eight full-scale registers from 0x20, reset 10011
// - High-voltage sink feedback bits reset connected
// - Indicator sink feedback bits reset connected
// - Pump gain: auto, fixed 1X, fixed 2X
// - Pump disable bit, reset enabled
// - Bank enables gate sink drive, reset off
// - Pattern enables for banks c-h, bits 2-7
// - Overvoltage limit and switching frequency select
// - Auto headroom, auto frequency, threshold 0xcf
// - PWM routing to a/b, zero detect on
// - PWM polarity, reset active high
// - Bank a code split over 0x40/0x41
// - Bank b code split over 0x42/0x43
// - Only high byte write launches new code
// - Banks c-h codes at 0x44 to 0x49
// - Each string sink follows bank a or b
module lbc_top import lbc_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    input  wire logic        SCL,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE,
    input  wire logic        PWM_IN,
    output logic             MAP_LINEAR_AB,
    output logic             MAP_LINEAR_CH,
    output logic             DITHER_EN_A,
    output logic             DITHER_EN_B,
    output logic [39:0]      FULL_SCALE_CODE,
    output logic [2:0]       HV_FB_EN,
    output logic [5:0]       IND_FB_EN,
    output logic             PUMP_OFF,
    output logic [1:0]       PUMP_GAIN,
    output logic [7:0]       BANK_EN,
    output logic [5:0]       PATTERN_EN,
    output logic [1:0]       OVP_SEL,
    output logic             FREQ_1MHZ,
    output logic             AUTO_HEADROOM,
    output logic             AUTO_FREQ,
    output logic [7:0]       AUTO_FREQ_THR,
    output logic             PWM_ZERO_DET,
    output logic             PWM_GATE_A,
    output logic             PWM_GATE_B,
    output logic [10:0]      BANK_A_CODE,
    output logic [10:0]      BANK_B_CODE,
    output logic             RAMP_START_A,
    output logic             RAMP_START_B,
    output logic [47:0]      BANK_CH_CODE,
    output logic [32:0]      HV_SINK_CODE,
    output logic [44:0]      HV_SINK_FS_UA
);
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] ptr;
    logic [7:0] rd_data;
    logic [3:0] brcfg_q;
    logic [1:0] dith_q;
    logic [4:0] fs_q [8];
    logic [2:0] hvfb_q;
    logic [5:0] indfb_q;
    logic [2:0] pump_q;
    logic [7:0] ben_q;
    logic [5:0] pat_q;
    logic [4:0] boost_q;
    logic [7:0] afthr_q;
    logic [3:0] pwm_q;
    logic [7:0] ch_q [6];
    logic [2:0] hvsel_q;
    logic [2:0] lo_a;
    logic [2:0] lo_b;
    logic [7:0] hi_a;
    logic [7:0] hi_b;
    logic [1:0] gain_q;
    logic [1:0] pwm_s;
    logic [1:0] gate_q;
    logic [32:0] hv_code_q;
    logic [44:0] hv_fs_q;
    logic [47:0] ch_code_q;

    // Register access over serial slave
    lbc_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_slave (
        .clk     (CLOCK),
        .rst_n   (RST_N),
        .scl_in  (SCL),
        .sda_in  (SDA_IN),
        .sda_oe  (SDA_OE),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .ptr_q   (ptr),
        .rd_data (rd_data)
    );
    assign SDA_OUT = 1'b0;

    lbc_split_word u_word_a (
        .clk      (CLOCK),
        .rst_n    (RST_N),
        .lo_we    (wr_en && wr_addr == A_A_LO),
        .hi_we    (wr_en && wr_addr == A_A_HI),
        .din      (wr_data),
        .lo_q     (lo_a),
        .hi_q     (hi_a),
        .word_q   (BANK_A_CODE),
        .launch_q (RAMP_START_A)
    );

    lbc_split_word u_word_b (
        .clk      (CLOCK),
        .rst_n    (RST_N),
        .lo_we    (wr_en && wr_addr == A_B_LO),
        .hi_we    (wr_en && wr_addr == A_B_HI),
        .din      (wr_data),
        .lo_q     (lo_b),
        .hi_q     (hi_b),
        .word_q   (BANK_B_CODE),
        .launch_q (RAMP_START_B)
    );

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            for (int i = 0; i < 8; i++) begin
                fs_q[i] <= R_FS;
            end
        end else if (wr_en && wr_addr >= A_FS_BASE && wr_addr <= A_FS_LAST) begin
            fs_q[wr_addr[2:0]] <= wr_data[4:0];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            for (int i = 0; i < 6; i++) begin
                ch_q[i] <= 8'h00;
            end
        end else if (wr_en && wr_addr >= A_CH_BASE && wr_addr <= A_CH_LAST) begin
            ch_q[3'(wr_addr - A_CH_BASE)] <= wr_data;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            hvsel_q <= R_HV_ASSIGN;
            brcfg_q <= 4'h0;
            hvfb_q  <= R_HV_FB;
            indfb_q <= R_IND_FB;
            pump_q  <= 3'h0;
            ben_q   <= 8'h00;
            pat_q   <= 6'h00;
            boost_q <= 5'h00;
            afthr_q <= R_AF_THR;
            pwm_q   <= R_PWM;
        end else if (wr_en) begin
            case (wr_addr)
                A_HV_ASSIGN:  hvsel_q <= wr_data[2:0];
                A_BRIGHT_CFG: brcfg_q <= wr_data[3:0];
                A_HV_FB:      hvfb_q  <= wr_data[2:0];
                A_IND_FB:     indfb_q <= wr_data[5:0];
                A_PUMP:       pump_q  <= wr_data[2:0];
                A_BANK_EN:    ben_q   <= wr_data;
                A_PAT_EN:     pat_q   <= wr_data[7:2];
                A_BOOST:      boost_q <= wr_data[4:0];
                A_AF_THR:     afthr_q <= wr_data;
                A_PWM:        pwm_q   <= wr_data[3:0];
                default:      pat_q   <= pat_q;
            endcase
        end
    end

    always_comb begin
        rd_data = 8'h00;
        if (ptr >= A_FS_BASE && ptr <= A_FS_LAST) begin
            rd_data = {3'h0, fs_q[ptr[2:0]]};
        end else if (ptr >= A_CH_BASE && ptr <= A_CH_LAST) begin
            rd_data = ch_q[3'(ptr - A_CH_BASE)];
        end else begin
            case (ptr)
                A_HV_ASSIGN:  rd_data = {5'h00, hvsel_q};
                A_BRIGHT_CFG: rd_data = {4'h0, brcfg_q};
                A_HV_FB:      rd_data = {5'h00, hvfb_q};
                A_IND_FB:     rd_data = {2'h0, indfb_q};
                A_PUMP:       rd_data = {5'h00, pump_q};
                A_BANK_EN:    rd_data = ben_q;
                A_PAT_EN:     rd_data = {pat_q, 2'h0};
                A_BOOST:      rd_data = {3'h0, boost_q};
                A_AF_THR:     rd_data = afthr_q;
                A_PWM:        rd_data = {4'h0, pwm_q};
                A_A_LO:       rd_data = {5'h00, lo_a};
                A_A_HI:       rd_data = hi_a;
                A_B_LO:       rd_data = {5'h00, lo_b};
                A_B_HI:       rd_data = hi_b;
                default:      rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            dith_q <= 2'h3;
        end else if (wr_en && wr_addr == A_BRIGHT_CFG) begin
            dith_q <= ~wr_data[3:2];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            gain_q <= GAIN_AUTO;
        end else if (!pump_q[2]) begin
            gain_q <= GAIN_AUTO;
        end else begin
            gain_q <= pump_q[1] ? GAIN_2X : GAIN_1X;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            pwm_s  <= 2'h0;
            gate_q <= 2'h3;
        end else begin
            pwm_s <= {pwm_s[0], PWM_IN};
            gate_q[0] <= pwm_q[B_PWM_A] ? (pwm_s[1] ~^ pwm_q[B_PWM_POL]) : 1'b1;
            gate_q[1] <= pwm_q[B_PWM_B] ? (pwm_s[1] ~^ pwm_q[B_PWM_POL]) : 1'b1;
        end
    end

    // String sinks follow bank a or b
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            hv_code_q <= '0;
            hv_fs_q   <= '0;
            ch_code_q <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (hvsel_q[i]) begin
                    hv_code_q[i*11 +: 11] <= ben_q[1] ? BANK_B_CODE : 11'h000;
                    hv_fs_q[i*15 +: 15]   <= fs_ua(fs_q[1]);
                end else begin
                    hv_code_q[i*11 +: 11] <= ben_q[0] ? BANK_A_CODE : 11'h000;
                    hv_fs_q[i*15 +: 15]   <= fs_ua(fs_q[0]);
                end
            end
            for (int i = 0; i < 6; i++) begin
                ch_code_q[i*8 +: 8] <= ben_q[i+2] ? ch_q[i] : 8'h00;
            end
        end
    end

    assign MAP_LINEAR_AB = brcfg_q[B_MAP_AB];
    assign MAP_LINEAR_CH = brcfg_q[B_MAP_CH];
    assign DITHER_EN_A   = dith_q[0];
    assign DITHER_EN_B   = dith_q[1];
    assign FULL_SCALE_CODE = {fs_q[7], fs_q[6], fs_q[5], fs_q[4],
                              fs_q[3], fs_q[2], fs_q[1], fs_q[0]};
    assign HV_SINK_FS_UA = hv_fs_q;
    assign HV_FB_EN      = hvfb_q;
    assign IND_FB_EN     = indfb_q;
    assign PUMP_OFF      = pump_q[0];
    assign PUMP_GAIN     = gain_q;
    assign BANK_EN       = ben_q;
    assign PATTERN_EN    = pat_q;
    assign OVP_SEL       = boost_q[2:1];
    assign FREQ_1MHZ     = boost_q[B_FREQ];
    assign AUTO_HEADROOM = boost_q[B_AUTO_HR];
    assign AUTO_FREQ     = boost_q[B_AUTO_F];
    assign AUTO_FREQ_THR = afthr_q;
    assign PWM_ZERO_DET  = pwm_q[B_PWM_ZD];
    assign PWM_GATE_A    = gate_q[0];
    assign PWM_GATE_B    = gate_q[1];
    assign BANK_CH_CODE  = ch_code_q;
    assign HV_SINK_CODE  = hv_code_q;

    // Checks
    property p_low_only;
        @(posedge CLOCK) disable iff (!RST_N)
        wr_en && wr_addr == A_A_LO |=> $stable(BANK_A_CODE) && !RAMP_START_A;
    endproperty
    a_low_only: assert property (p_low_only) else $error("low byte moved code");

    property p_high_a;
        @(posedge CLOCK) disable iff (!RST_N)
        wr_en && wr_addr == A_A_HI |=> RAMP_START_A && BANK_A_CODE == {$past(wr_data), lo_a};
    endproperty
    a_high_a: assert property (p_high_a) else $error("bank a word wrong");

    property p_high_b;
        @(posedge CLOCK) disable iff (!RST_N)
        wr_en && wr_addr == A_B_HI |=> RAMP_START_B ##1 !RAMP_START_B;
    endproperty
    a_high_b: assert property (p_high_b) else $error("bank b launch wrong");

    property p_fs_reset;
        @(posedge CLOCK) disable iff (!RST_N)
        !$past(RST_N) |-> FULL_SCALE_CODE[39:35] == R_FS && FULL_SCALE_CODE[4:0] == R_FS;
    endproperty
    a_fs_reset: assert property (p_fs_reset) else $error("full scale reset");

    property p_off_bank;
        @(posedge CLOCK) disable iff (!RST_N)
        !hvsel_q[0] && !ben_q[0] |=> HV_SINK_CODE[10:0] == 11'h000;
    endproperty
    a_off_bank: assert property (p_off_bank) else $error("disabled bank drives");

    property p_gain;
        @(posedge CLOCK) disable iff (!RST_N)
        pump_q[2:1] == 2'b11 |=> PUMP_GAIN == GAIN_2X;
    endproperty
    a_gain: assert property (p_gain) else $error("pump gain decode");

    property p_assign_b;
        @(posedge CLOCK) disable iff (!RST_N)
        hvsel_q[1] && ben_q[1] |=> HV_SINK_CODE[21:11] == $past(BANK_B_CODE);
    endproperty
    a_assign_b: assert property (p_assign_b) else $error("sink not on bank b");

    property p_rsvd;
        @(posedge CLOCK) disable iff (!RST_N)
        ptr == A_BRIGHT_CFG || ptr == A_PWM |-> rd_data[7:4] == 4'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read");

    property p_fs_ua;
        @(posedge CLOCK) disable iff (!RST_N)
        !hvsel_q[0] |=> HV_SINK_FS_UA[14:0] == FS_BASE_UA + 15'($past(fs_q[0])) * FS_STEP_UA;
    endproperty
    a_fs_ua: assert property (p_fs_ua) else $error("full scale current");

    c_ramp_a: cover property (@(posedge CLOCK) disable iff (!RST_N) RAMP_START_A);
    c_gain_1x: cover property (@(posedge CLOCK) disable iff (!RST_N) PUMP_GAIN == GAIN_1X);
    c_read: cover property (@(posedge CLOCK) disable iff (!RST_N) SDA_OE && ptr == A_AF_THR);
endmodule

// ---- design/lbc_pkg.sv ----
// Shared constants and types for the lighting configuration register bank
package lbc_pkg;
    localparam logic [7:0] A_HV_ASSIGN  = 8'h10;
    localparam logic [7:0] A_BRIGHT_CFG = 8'h1f;
    localparam logic [7:0] A_FS_BASE    = 8'h20;
    localparam logic [7:0] A_FS_LAST    = 8'h27;
    localparam logic [7:0] A_HV_FB      = 8'h28;
    localparam logic [7:0] A_IND_FB     = 8'h29;
    localparam logic [7:0] A_PUMP       = 8'h2a;
    localparam logic [7:0] A_BANK_EN    = 8'h2b;
    localparam logic [7:0] A_PAT_EN     = 8'h2c;
    localparam logic [7:0] A_BOOST      = 8'h2d;
    localparam logic [7:0] A_AF_THR     = 8'h2e;
    localparam logic [7:0] A_PWM        = 8'h2f;
    localparam logic [7:0] A_A_LO       = 8'h40;
    localparam logic [7:0] A_A_HI       = 8'h41;
    localparam logic [7:0] A_B_LO       = 8'h42;
    localparam logic [7:0] A_B_HI       = 8'h43;
    localparam logic [7:0] A_CH_BASE    = 8'h44;
    localparam logic [7:0] A_CH_LAST    = 8'h49;

    localparam logic [2:0] R_HV_ASSIGN  = 3'h6;
    localparam logic [4:0] R_FS         = 5'h13;
    localparam logic [2:0] R_HV_FB      = 3'h7;
    localparam logic [5:0] R_IND_FB     = 6'h3f;
    localparam logic [7:0] R_AF_THR     = 8'hcf;
    localparam logic [3:0] R_PWM        = 4'hc;

    localparam int B_MAP_AB  = 0;
    localparam int B_MAP_CH  = 1;
    localparam int B_DITH_A  = 2;
    localparam int B_DITH_B  = 3;
    localparam int B_PWM_A   = 0;
    localparam int B_PWM_B   = 1;
    localparam int B_PWM_POL = 2;
    localparam int B_PWM_ZD  = 3;
    localparam int B_FREQ    = 0;
    localparam int B_AUTO_F  = 3;
    localparam int B_AUTO_HR = 4;

    localparam logic [14:0] FS_BASE_UA = 15'h1388;
    localparam logic [14:0] FS_STEP_UA = 15'h0320;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DEV  = 3'b001,
        ST_DACK = 3'b011,
        ST_RX   = 3'b010,
        ST_RACK = 3'b110,
        ST_TX   = 3'b111,
        ST_TACK = 3'b101
    } lbc_i2c_st_t;

    typedef enum logic [1:0] {
        GAIN_AUTO = 2'b00,
        GAIN_1X   = 2'b01,
        GAIN_2X   = 2'b10
    } lbc_gain_t;

    function automatic logic [14:0] fs_ua(input logic [4:0] code);
        fs_ua = FS_BASE_UA + 15'(code) * FS_STEP_UA;
    endfunction
endpackage

// ---- design/lbc_split_word.sv ----
// Split brightness word: low and high byte latches, applied on high write
`timescale 1ns/1ns
module lbc_split_word import lbc_pkg::*; #(
    parameter int LO_W = 3,
    parameter int HI_W = 8
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 lo_we,
    input  wire logic                 hi_we,
    input  wire logic [7:0]           din,
    output logic      [LO_W-1:0]      lo_q,
    output logic      [HI_W-1:0]      hi_q,
    output logic      [LO_W+HI_W-1:0] word_q,
    output logic                      launch_q
);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lo_q <= '0;
            hi_q <= '0;
        end else begin
            if (lo_we) begin
                lo_q <= din[LO_W-1:0];
            end
            if (hi_we) begin
                hi_q <= din[HI_W-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            word_q   <= '0;
            launch_q <= 1'b0;
        end else begin
            launch_q <= hi_we;
            if (hi_we) begin
                word_q <= {din[HI_W-1:0], lo_q};
            end
        end
    end
endmodule

// ---- design/lbc_i2c_slave.sv ----
// Serial control slave: device address, register pointer, auto-increment
`timescale 1ns/1ns
module lbc_i2c_slave import lbc_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_oe,
    output logic            wr_en,
    output logic      [7:0] wr_addr,
    output logic      [7:0] wr_data,
    output logic      [7:0] ptr_q,
    input  wire logic [7:0] rd_data
);
    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    lbc_i2c_st_t st_q;
    logic [3:0]  cnt_q;
    logic [7:0]  sh_q;
    logic        rw_q;
    logic        first_q;
    logic        rise;
    logic        fall;
    logic        start;
    logic        stop;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
        end else begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
        end
    end

    assign rise  = scl_s[1] & ~scl_s[2];
    assign fall  = ~scl_s[1] & scl_s[2];
    assign start = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
    assign stop  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

    // Byte address then data, pointer auto-increments
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= ST_IDLE; cnt_q <= 4'h0; sh_q <= 8'h00; rw_q <= 1'b0;
            first_q <= 1'b0; sda_oe <= 1'b0; wr_en <= 1'b0;
            wr_addr <= 8'h00; wr_data <= 8'h00; ptr_q <= 8'h00;
        end else begin
            wr_en <= 1'b0;
            if (start) begin
                st_q <= ST_DEV; cnt_q <= 4'h0; sda_oe <= 1'b0;
            end else if (stop) begin
                st_q <= ST_IDLE; sda_oe <= 1'b0;
            end else begin
                case (st_q)
                    ST_DEV, ST_RX: begin
                        if (rise) begin
                            sh_q <= {sh_q[6:0], sda_s[1]}; cnt_q <= cnt_q + 4'h1;
                        end else if (fall && cnt_q == 4'h8) begin
                            cnt_q <= 4'h0;
                            if (st_q == ST_RX) begin
                                sda_oe <= 1'b1; st_q <= ST_RACK;
                                if (first_q) begin
                                    ptr_q <= sh_q; first_q <= 1'b0;
                                end else begin
                                    wr_en <= 1'b1; wr_addr <= ptr_q; wr_data <= sh_q;
                                    ptr_q <= ptr_q + 8'h01;
                                end
                            end else if (sh_q[7:1] == DEV_ADDR) begin
                                sda_oe <= 1'b1; rw_q <= sh_q[0]; st_q <= ST_DACK;
                            end else begin
                                st_q <= ST_IDLE;
                            end
                        end
                    end
                    ST_DACK: if (fall) begin
                        cnt_q <= 4'h0;
                        if (rw_q) begin
                            sh_q <= rd_data; sda_oe <= ~rd_data[7]; st_q <= ST_TX;
                        end else begin
                            sda_oe <= 1'b0; first_q <= 1'b1; st_q <= ST_RX;
                        end
                    end
                    ST_RACK: if (fall) begin
                        sda_oe <= 1'b0; st_q <= ST_RX;
                    end
                    ST_TX: begin
                        if (rise) begin
                            cnt_q <= cnt_q + 4'h1;
                        end else if (fall && cnt_q == 4'h8) begin
                            sda_oe <= 1'b0; cnt_q <= 4'h0; ptr_q <= ptr_q + 8'h01;
                            st_q <= ST_TACK;
                        end else if (fall) begin
                            sh_q <= {sh_q[6:0], 1'b0}; sda_oe <= ~sh_q[6];
                        end
                    end
                    ST_TACK: begin
                        if (rise) begin
                            cnt_q <= 4'h1; rw_q <= ~sda_s[1];
                        end else if (fall && cnt_q == 4'h1) begin
                            cnt_q <= 4'h0;
                            if (rw_q) begin
                                sh_q <= rd_data; sda_oe <= ~rd_data[7]; st_q <= ST_TX;
                            end else begin
                                st_q <= ST_IDLE;
                            end
                        end
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

// ---- sim/lbc_host.sv ----
// Host model that frames register writes and reads on the two-wire port
`timescale 1ns/1ns
module lbc_host (
    input  wire logic clk,
    input  wire logic sda_oe,
    output logic      scl,
    output logic      sda
);
    logic lo = 1'b0;
    initial scl = 1'b1;
    // Open-drain line with pull-up
    assign sda = !(lo || sda_oe);
    task automatic hp;
        repeat (10) @(negedge clk);
    endtask
    task automatic bt(input logic b, output logic r);
        repeat (5) @(negedge clk);
        lo = !b;
        hp;
        scl = 1'b1;
        hp;
        r = sda;
        scl = 1'b0;
    endtask
    task automatic xb(input logic [7:0] d, input logic k, output logic [7:0] q, output logic n);
        for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
        bt(k, n);
    endtask
    // Start when l0 is 0, stop when 1
    task automatic cond(input logic l0);
        lo = l0;
        hp;
        scl = 1'b1;
        hp;
        lo = !l0;
        hp;
        scl = l0;
    endtask
    task automatic xfer(input logic [6:0] dv, input logic [7:0] a, d, input logic rnw,
                        output logic [7:0] q, output logic n);
        logic [7:0] t;
        logic       n1;
        cond(1'b0);
        xb({dv, 1'b0}, 1'b1, t, n);
        xb(a, 1'b1, t, n1);
        if (rnw) begin
            cond(1'b0);
            xb({dv, 1'b1}, 1'b1, t, n1);
        end
        xb(rnw ? 8'hff : d, 1'b1, q, n1);
        cond(1'b1);
    endtask
endmodule

// ---- sim/lbc_top_tb.sv ----
// Self-checking bench for the lighting configuration register bank
`timescale 1ns/1ns
module lbc_top_tb import lbc_pkg::*;;
    logic        CLOCK, RST_N, SCL, SDA, SDA_OE, MAP_LINEAR_AB, MAP_LINEAR_CH, n;
    logic        DITHER_EN_A, DITHER_EN_B, PUMP_OFF, FREQ_1MHZ, AUTO_HEADROOM, AUTO_FREQ;
    logic        PWM_IN, PWM_ZERO_DET, PWM_GATE_A, PWM_GATE_B, RAMP_START_A, RAMP_START_B;
    logic [1:0]  PUMP_GAIN, OVP_SEL;
    logic [2:0]  HV_FB_EN;
    logic [5:0]  IND_FB_EN, PATTERN_EN;
    logic [7:0]  BANK_EN, AUTO_FREQ_THR, q;
    logic [10:0] BANK_A_CODE, BANK_B_CODE;
    logic [32:0] HV_SINK_CODE;
    logic [39:0] FULL_SCALE_CODE;
    logic [44:0] HV_SINK_FS_UA;
    logic [47:0] BANK_CH_CODE;
    int          miscompares = 0, n_tests = 0, ramps = 0;
    logic [23:0] rows [16] = '{24'h1fff0f, 24'h20e505, 24'h271f1f, 24'h28fa02, 24'h29c101,
        24'h2aff07, 24'h2ba5a5, 24'h2cfffc, 24'h2dff1f, 24'h2e3535, 24'h2ff303,
        24'h40ff07, 24'h420505, 24'h448181, 24'h497e7e, 24'h305500};

    lbc_top dut (.SDA_IN(SDA), .SDA_OUT(), .*);
    lbc_host host (.clk(CLOCK), .sda_oe(SDA_OE), .scl(SCL), .sda(SDA));

    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end
    always @(posedge CLOCK) ramps += RAMP_START_A + RAMP_START_B;
    task automatic chk(input string nm, input logic [63:0] s, e);
        n_tests++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic w(input logic [7:0] a, d);
        host.xfer(7'h2a, a, d, 1'b0, q, n);
        chk("ack", n, 1'b0);
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #1_000_000;
        miscompares++;
        report_and_stop;
    end
    initial begin
        RST_N = 1'b0;
        PWM_IN = 1'b1;
        repeat (2) @(negedge CLOCK);
        RST_N = 1'b1;
        // low bytes written before high bytes
        foreach (rows[i]) begin
            w(rows[i][23:16], rows[i][15:8]);
            host.xfer(7'h2a, rows[i][23:16], 8'h00, 1'b1, q, n);
            chk("readback", q, rows[i][7:0]);
        end
        chk("cfg", {DITHER_EN_A, DITHER_EN_B, MAP_LINEAR_AB, MAP_LINEAR_CH}, 4'h3);
        chk("pump", {PUMP_OFF, PUMP_GAIN}, {1'b1, GAIN_2X});
        chk("boost", {OVP_SEL, FREQ_1MHZ, AUTO_FREQ, AUTO_HEADROOM, AUTO_FREQ_THR}, 13'h1f35);
        chk("fb", {HV_FB_EN, IND_FB_EN, BANK_EN, PATTERN_EN}, 23'h20697f);
        chk("fs", FULL_SCALE_CODE, {5'h1f, {6{5'h13}}, 5'h05});
        chk("chcode", BANK_CH_CODE, {8'h7e, 32'h0, 8'h81});
        chk("pwm0", {PWM_ZERO_DET, PWM_GATE_A, PWM_GATE_B}, 3'h0);
        PWM_IN = 1'b0;
        repeat (4) @(negedge CLOCK);
        chk("pwm1", {PWM_ZERO_DET, PWM_GATE_A, PWM_GATE_B}, 3'h3);
        w(A_PUMP, 8'h04);
        chk("gain1", PUMP_GAIN, GAIN_1X);
        w(A_PUMP, 8'h02);
        chk("gain0", {PUMP_OFF, PUMP_GAIN}, {1'b0, GAIN_AUTO});
        chk("lowonly", {BANK_A_CODE, BANK_B_CODE, ramps[3:0]}, 26'h0);
        w(A_A_HI, 8'ha3);
        chk("codea", {BANK_A_CODE, ramps[3:0]}, {11'h51f, 4'h1});
        w(A_B_HI, 8'h12);
        chk("codeb", {BANK_B_CODE, ramps[3:0]}, {11'h095, 4'h2});
        chk("sinks", HV_SINK_CODE, {22'h0, 11'h51f});
        chk("sinkfs", HV_SINK_FS_UA, {15'h4ee8, 15'h4ee8, 15'h2328});
        w(A_BANK_EN, 8'h03);
        chk("sinks2", HV_SINK_CODE, {11'h095, 11'h095, 11'h51f});
        host.xfer(7'h15, A_BANK_EN, 8'h00, 1'b0, q, n);
        chk("nack", {n, BANK_EN}, 9'h103);
        RST_N = 1'b0;
        repeat (2) @(negedge CLOCK);
        RST_N = 1'b1;
        repeat (4) @(negedge CLOCK);
        chk("rst", {DITHER_EN_A, DITHER_EN_B, MAP_LINEAR_AB, MAP_LINEAR_CH, PUMP_OFF, PUMP_GAIN,
            BANK_EN, PATTERN_EN, OVP_SEL, FREQ_1MHZ, AUTO_HEADROOM, AUTO_FREQ, AUTO_FREQ_THR,
            PWM_ZERO_DET, HV_FB_EN, IND_FB_EN}, {4'hc, 22'h0, 8'hcf, 1'b1, 3'h7, 6'h3f});
        chk("rstfs", {FULL_SCALE_CODE, BANK_A_CODE, PWM_GATE_A}, {{8{5'h13}}, 11'h0, 1'b1});
        host.xfer(7'h2a, A_PWM, 8'h00, 1'b1, q, n);
        chk("rstpwm", q, 8'h0c);
        report_and_stop;
    end
endmodule
